// file: src/slpm_counters.sv
/*
  Near-end section and line performance-monitoring counters for one
  optical port, with a plain register port and one level interrupt.
  Assumes a one-second tick pulse and defect inputs arriving from
  outside the core clock domain, all synchronised here.
*/
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
// How it works
// - Add B1 errors, up to eight, per frame.
// - Section errored second on error, SEF, LOS.
// - Section severe second at K errors, SEF, LOS.
// - Count every SEF second as framing second.
// - Add B2 errors, up to 8xN, per frame.
// - Line errored second on error or AIS.
// - Line severe second at K errors or AIS.
// - Ten severe seconds enter, ten clean leave unavailability.
// - Count line failure events, AIS or lower-layer.
// - Credit failure only to its starting period.
// - Working card counts switches away and back.
// - Protection card counts switches away and back.
// - Switch counters run only when revertive.
// - Working line counts seconds carried on protection.
// - Protection line counts seconds carrying service.
// - Ring, span, ring-working counts never increment.
module slpm_counters
  import slpm_pkg::*;
#(
  parameter int STS_N = 3
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              sec_tick,
  input  wire slpm_line_t        line_in,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [CNT_W-1:0]  reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [CNT_W-1:0]       reg_rdata,
  output logic                   irq,
  output logic [CNT_W-1:0]       ring_working_switch_count,
  output logic [CNT_W-1:0]       span_switch_count,
  output logic [CNT_W-1:0]       ring_switch_count,
  output logic [CNT_W-1:0]       ring_working_switch_duration,
  output logic [CNT_W-1:0]       span_switch_duration,
  output logic [CNT_W-1:0]       ring_switch_duration
);

  // One frame reports at most eight section and 8 x N line parity errors.
  localparam logic [3:0] B1_MAX = 4'h8;
  localparam logic [7:0] B2_MAX = 8'(8 * STS_N);

  typedef enum logic [1:0] {
    SLPM_AVAIL   = 2'b01,
    SLPM_UNAVAIL = 2'b10
  } slpm_avail_t;

  // All state of the block lives in one word, filled by the combinational process.
  typedef struct packed {
    slpm_line_t       sync1;
    slpm_line_t       sync2;
    logic             tick1;
    logic             tick2;
    logic             tick_d;
    logic             frame_d;
    logic [PERR_W-1:0] b1_acc;
    logic [PERR_W-1:0] b2_acc;
    logic             sef_seen;
    logic             los_seen;
    logic             ais_seen;
    logic             prot_seen;
    logic             fail_d;
    logic             prot_d;
    slpm_avail_t      avail;
    logic [AVAIL_W-1:0] run;
    logic [CNT_W-1:0] uas_pend;
    slpm_counts_t     cnt;
    logic [2:0]       ctrl;
    logic [ERR_W-1:0] sec_k;
    logic [ERR_W-1:0] line_k;
    logic [EVT_W-1:0] irq_stat;
    logic [EVT_W-1:0] irq_mask;
    logic [CNT_W-1:0] rdata;
  } slpm_state_t;

  slpm_state_t st;
  slpm_state_t next_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Event and second counters stick at all ones rather than wrap; cv_s and cv_l wrap.
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v == '1) ? v : v + 1'b1;
  endfunction

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] d);
    logic [CNT_W:0] s;
    s = {1'b0, v} + {1'b0, d};
    return s[CNT_W] ? '1 : s[CNT_W-1:0];
  endfunction

  // Unavailable time never wraps below zero when the clean run is taken back.
  function automatic logic [CNT_W-1:0] sat_sub(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] d);
    return (v < d) ? '0 : v - d;
  endfunction

  // Clamps one frame's error count to what its parity code can report.
  function automatic logic [PERR_W-1:0] clamp_add(input logic [PERR_W-1:0] acc,
                                                  input logic [7:0] n,
                                                  input logic [7:0] lim);
    logic [7:0] c;
    c = (n > lim) ? lim : n;
    return acc + PERR_W'(c);
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic            tick;
    logic            fr;
    logic            es_s_now;
    logic            section_severe_seconds_now;
    logic            es_l_now;
    logic            line_severe_seconds_now;
    logic            revert;
    logic            fail_now;
    logic [EVT_W-1:0] ev;
    logic [CNT_W-1:0] wmask;
    logic            clear_wr;
    tick      = 1'b0;
    fr        = 1'b0;
    es_s_now  = 1'b0;
    section_severe_seconds_now = 1'b0;
    es_l_now  = 1'b0;
    line_severe_seconds_now = 1'b0;
    revert    = 1'b0;
    fail_now  = 1'b0;
    wmask     = '0;
    clear_wr  = 1'b0;
    next_st = st;
    ev      = '0;
    // The whole line word crosses on two flops; the error counts are
    // only taken at the frame edge, after they have stood for two cycles.
    next_st.sync1  = line_in;
    next_st.sync2  = st.sync1;
    next_st.tick1  = sec_tick;
    next_st.tick2  = st.tick1;
    next_st.tick_d = st.tick2;
    next_st.frame_d = st.sync2.frame;
    // The delayed copies reset low like the idle inputs, so reset
    // release never looks like a tick or a frame edge.
    tick   = st.tick2 & ~st.tick_d;
    fr     = st.sync2.frame & ~st.frame_d;
    revert = st.ctrl[CTRL_REVERTIVE];

    // Per-second accumulation of parity errors and defects.
    if (fr) begin
      next_st.b1_acc = clamp_add(st.b1_acc, {4'h0, st.sync2.b1_errs}, {4'h0, B1_MAX});
      next_st.b2_acc = clamp_add(st.b2_acc, st.sync2.b2_errs, B2_MAX);
    end
    if (st.sync2.sef) next_st.sef_seen = 1'b1;
    if (st.sync2.los) next_st.los_seen = 1'b1;
    if (st.sync2.ais_l) next_st.ais_seen = 1'b1;
    if (st.sync2.on_protection) next_st.prot_seen = 1'b1;

    // Failure events count in the period they start in.
    fail_now       = st.sync2.ais_l_fail | st.sync2.lower_fail;
    next_st.fail_d = fail_now;
    if (fail_now && !st.fail_d) begin
      next_st.cnt.fc_l = sat_inc(st.cnt.fc_l);
      ev[EV_FAIL]      = 1'b1;
    end

    // Service moves between lines; in revertive mode both card roles count each move.
    next_st.prot_d = st.sync2.on_protection;
    if (revert && (st.sync2.on_protection != st.prot_d)) begin
      next_st.cnt.protection_switch_count = sat_inc(st.cnt.protection_switch_count);
      ev[EV_SWITCH]   = 1'b1;
    end

    // Close the second.
    es_s_now  = (st.b1_acc != '0) | st.sef_seen | st.los_seen;
    section_severe_seconds_now = (st.b1_acc >= PERR_W'(st.sec_k)) | st.sef_seen | st.los_seen;
    es_l_now  = (st.b2_acc != '0) | st.ais_seen;
    line_severe_seconds_now = (st.b2_acc >= PERR_W'(st.line_k)) | st.ais_seen;
    if (tick) begin
      ev[EV_SECOND] = 1'b1;
      next_st.cnt.cv_s = st.cnt.cv_s + CNT_W'(st.b1_acc);
      next_st.cnt.cv_l = st.cnt.cv_l + CNT_W'(st.b2_acc);
      if (es_s_now) next_st.cnt.es_s = sat_inc(st.cnt.es_s);
      if (section_severe_seconds_now) begin
        next_st.cnt.section_severe_seconds = sat_inc(st.cnt.section_severe_seconds);
        ev[EV_SECTION_SEVERE_SECONDS]      = 1'b1;
      end
      if (st.sef_seen) next_st.cnt.severe_framing_seconds = sat_inc(st.cnt.severe_framing_seconds);
      if (es_l_now) next_st.cnt.es_l = sat_inc(st.cnt.es_l);
      if (line_severe_seconds_now) begin
        next_st.cnt.line_severe_seconds = sat_inc(st.cnt.line_severe_seconds);
        ev[EV_LINE_SEVERE_SECONDS]      = 1'b1;
      end
      // In revertive mode, on either card role a second counts when service sat on the
      // protection line at any time in it.
      if (revert && st.prot_seen) begin
        next_st.cnt.protection_switch_duration = sat_inc(st.cnt.protection_switch_duration);
      end

      // Unavailability: the ten seconds that trigger the change belong
      // to the new state, so pending counts are credited or dropped.
      unique case (st.avail)
        SLPM_AVAIL: begin
          if (line_severe_seconds_now) begin
            next_st.run      = st.run + 1'b1;
            next_st.uas_pend = st.uas_pend + 1'b1;
            if (st.run == AVAIL_W'(AVAIL_N - 1)) begin
              next_st.avail     = SLPM_UNAVAIL;
              next_st.cnt.line_unavailable_seconds = sat_add(st.cnt.line_unavailable_seconds, st.uas_pend + 1'b1);
              next_st.run       = '0;
              next_st.uas_pend  = '0;
              ev[EV_UNAVAIL]    = 1'b1;
            end
          end else begin
            next_st.run      = '0;
            next_st.uas_pend = '0;
          end
        end
        // Clean seconds count as unavailable until the tenth, which takes
        // the nine before it back out.
        SLPM_UNAVAIL: begin
          if (!line_severe_seconds_now) begin
            next_st.run = st.run + 1'b1;
            if (st.run == AVAIL_W'(AVAIL_N - 1)) begin
              next_st.avail     = SLPM_AVAIL;
              next_st.cnt.line_unavailable_seconds = sat_sub(st.cnt.line_unavailable_seconds, CNT_W'(AVAIL_N - 1));
              next_st.run       = '0;
              ev[EV_UNAVAIL]    = 1'b1;
            end else begin
              next_st.cnt.line_unavailable_seconds = sat_inc(st.cnt.line_unavailable_seconds);
            end
          end else begin
            next_st.run       = '0;
            next_st.cnt.line_unavailable_seconds = sat_inc(st.cnt.line_unavailable_seconds);
          end
        end
      endcase

      // A frame mark that falls on the tick opens the next second.
      next_st.b1_acc    = '0;
      next_st.b2_acc    = '0;
      if (fr) begin
        next_st.b1_acc = clamp_add('0, {4'h0, st.sync2.b1_errs}, {4'h0, B1_MAX});
        next_st.b2_acc = clamp_add('0, st.sync2.b2_errs, B2_MAX);
      end
      next_st.sef_seen  = st.sync2.sef;
      next_st.los_seen  = st.sync2.los;
      next_st.ais_seen  = st.sync2.ais_l;
      next_st.prot_seen = st.sync2.on_protection;
    end

    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:     next_st.ctrl   = reg_wdata[2:0];
        REG_SEC_K:    next_st.sec_k  = reg_wdata[ERR_W-1:0];
        REG_LINE_K:   next_st.line_k = reg_wdata[ERR_W-1:0];
        REG_IRQ_STAT: wmask          = reg_wdata;
        REG_IRQ_MASK: next_st.irq_mask = reg_wdata[EVT_W-1:0];
        // Unmapped writes are dropped.
        default:      ;
      endcase
    end
    clear_wr = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_CLEAR];
    if (clear_wr) begin
      next_st.cnt   = '0;
      next_st.avail = SLPM_AVAIL;
      next_st.run   = '0;
      next_st.uas_pend = '0;
    end
    next_st.ctrl[CTRL_CLEAR] = 1'b0;
    // Set wins over a write-one clear.
    next_st.irq_stat = (st.irq_stat & ~wmask[EVT_W-1:0]) | ev;

    // Register reads, answered in the next cycle.
    next_st.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:     next_st.rdata = CNT_W'(st.ctrl);
        REG_SEC_K:    next_st.rdata = CNT_W'(st.sec_k);
        REG_LINE_K:   next_st.rdata = CNT_W'(st.line_k);
        REG_IRQ_STAT: next_st.rdata = CNT_W'(st.irq_stat);
        REG_IRQ_MASK: next_st.rdata = CNT_W'(st.irq_mask);
        REG_STATE:    next_st.rdata = CNT_W'({st.prot_d, st.fail_d, st.avail});
        REG_CV_S:     next_st.rdata = st.cnt.cv_s;
        REG_ES_S:     next_st.rdata = st.cnt.es_s;
        REG_SECTION_SEVERE_SECONDS:    next_st.rdata = st.cnt.section_severe_seconds;
        REG_SEVERE_FRAMING_SECONDS:   next_st.rdata = st.cnt.severe_framing_seconds;
        REG_CV_L:     next_st.rdata = st.cnt.cv_l;
        REG_ES_L:     next_st.rdata = st.cnt.es_l;
        REG_LINE_SEVERE_SECONDS:    next_st.rdata = st.cnt.line_severe_seconds;
        REG_LINE_UNAVAILABLE_SECONDS:    next_st.rdata = st.cnt.line_unavailable_seconds;
        REG_FC_L:     next_st.rdata = st.cnt.fc_l;
        REG_PSC:      next_st.rdata = st.cnt.protection_switch_count;
        REG_PSD:      next_st.rdata = st.cnt.protection_switch_duration;
        // Unmapped addresses read as zero.
        default:      next_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    // Reset loads the default thresholds and SLPM_AVAIL; everything else starts at zero.
    if (srst) begin
      st        <= '0;
      st.avail  <= SLPM_AVAIL;
      st.sec_k  <= SEC_K_RST;
      st.line_k <= LINE_K_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign irq       = |(st.irq_stat & st.irq_mask);

  // Ring protection is not available on this port.
  assign ring_working_switch_count    = '0;
  assign span_switch_count            = '0;
  assign ring_switch_count            = '0;
  assign ring_working_switch_duration = '0;
  assign span_switch_duration         = '0;
  assign ring_switch_duration         = '0;

endmodule

// file: src/slpm_pkg.sv
/*
  Package for the section and line performance-monitoring counters:
  register map, field layouts, widths and the carrier structs.
  Assumes a 32-bit register port with read data one cycle after the strobe.
*/
package slpm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CNT_W    = 32;
  localparam int ADDR_W   = 7;
  localparam int ERR_W    = 16;
  localparam int PERR_W   = 24;
  localparam int AVAIL_N  = 10;
  localparam int AVAIL_W  = 4;
  localparam int EVT_W    = 6;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL      = 7'h00;
  localparam logic [ADDR_W-1:0] REG_SEC_K     = 7'h04;
  localparam logic [ADDR_W-1:0] REG_LINE_K    = 7'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 7'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 7'h10;
  localparam logic [ADDR_W-1:0] REG_STATE     = 7'h14;
  localparam logic [ADDR_W-1:0] REG_CV_S      = 7'h18;
  localparam logic [ADDR_W-1:0] REG_ES_S      = 7'h1c;
  localparam logic [ADDR_W-1:0] REG_SECTION_SEVERE_SECONDS     = 7'h20;
  localparam logic [ADDR_W-1:0] REG_SEVERE_FRAMING_SECONDS    = 7'h24;
  localparam logic [ADDR_W-1:0] REG_CV_L      = 7'h28;
  localparam logic [ADDR_W-1:0] REG_ES_L      = 7'h2c;
  localparam logic [ADDR_W-1:0] REG_LINE_SEVERE_SECONDS     = 7'h30;
  localparam logic [ADDR_W-1:0] REG_LINE_UNAVAILABLE_SECONDS     = 7'h34;
  localparam logic [ADDR_W-1:0] REG_FC_L      = 7'h38;
  localparam logic [ADDR_W-1:0] REG_PSC       = 7'h3c;
  localparam logic [ADDR_W-1:0] REG_PSD       = 7'h40;

  // ----------------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_REVERTIVE = 0;
  localparam int CTRL_PROT_CARD = 1;
  localparam int CTRL_CLEAR     = 2;
  localparam logic [ERR_W-1:0] SEC_K_RST  = 16'h0001;
  localparam logic [ERR_W-1:0] LINE_K_RST = 16'h0001;

  // Interrupt status bits.
  localparam int EV_SECOND  = 0;
  localparam int EV_SECTION_SEVERE_SECONDS   = 1;
  localparam int EV_LINE_SEVERE_SECONDS   = 2;
  localparam int EV_UNAVAIL = 3;
  localparam int EV_FAIL    = 4;
  localparam int EV_SWITCH  = 5;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       frame;
    logic [3:0] b1_errs;
    logic [7:0] b2_errs;
    logic       sef;
    logic       los;
    logic       ais_l;
    logic       lower_fail;
    logic       ais_l_fail;
    logic       on_protection;
  } slpm_line_t;

  typedef struct packed {
    logic [CNT_W-1:0] cv_s;
    logic [CNT_W-1:0] es_s;
    logic [CNT_W-1:0] section_severe_seconds;
    logic [CNT_W-1:0] severe_framing_seconds;
    logic [CNT_W-1:0] cv_l;
    logic [CNT_W-1:0] es_l;
    logic [CNT_W-1:0] line_severe_seconds;
    logic [CNT_W-1:0] line_unavailable_seconds;
    logic [CNT_W-1:0] fc_l;
    logic [CNT_W-1:0] protection_switch_count;
    logic [CNT_W-1:0] protection_switch_duration;
  } slpm_counts_t;

endpackage

// file: testbench/slpm_props.sv
/*
  Concurrent checks on the ports of the performance-monitoring counter block.
  Assumes it is bound to slpm_counters and sees only that module's ports.
*/
`timescale 1ns/1ps
module slpm_props
  import slpm_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [CNT_W-1:0]  reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [CNT_W-1:0]  reg_rdata,
  input wire logic              irq,
  input wire logic [CNT_W-1:0]  ring_working_switch_count,
  input wire logic [CNT_W-1:0]  span_switch_count,
  input wire logic [CNT_W-1:0]  ring_switch_count,
  input wire logic [CNT_W-1:0]  ring_working_switch_duration,
  input wire logic [CNT_W-1:0]  span_switch_duration,
  input wire logic [CNT_W-1:0]  ring_switch_duration
);
  // ----------------------------------------------------------------------
  // Shadow of the mask and of whether revertive mode was ever enabled
  // ----------------------------------------------------------------------
  logic [EVT_W-1:0] mask_q;
  logic             rev_seen;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask_q   <= '0;
      rev_seen <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_IRQ_MASK) mask_q <= reg_wdata[EVT_W-1:0];
      if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_REVERTIVE]) rev_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  ring_cnt_zero_a: assert property (
    ring_working_switch_count == '0 && ring_switch_count == '0)
    else $error("ring switch count moved");
  span_cnt_zero_a: assert property (
    span_switch_count == '0 && span_switch_duration == '0)
    else $error("span switch counter moved");
  ring_dur_zero_a: assert property (
    ring_working_switch_duration == '0 && ring_switch_duration == '0)
    else $error("ring switch duration moved");
  unmapped_read_a: assert property (reg_rd && reg_addr > REG_PSD |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");
  psc_idle_a: assert property (
    reg_rd && reg_addr == REG_PSC && !rev_seen |=> reg_rdata == '0)
    else $error("switch count moved without revertive mode");
  psd_idle_a: assert property (
    reg_rd && reg_addr == REG_PSD && !rev_seen |=> reg_rdata == '0)
    else $error("switch duration moved without revertive mode");
  irq_masked_a: assert property (irq |-> mask_q != '0 || $past(mask_q) != '0)
    else $error("interrupt with empty mask");
  mask_off_a: assert property (
    reg_wr && reg_addr == REG_IRQ_MASK && reg_wdata[EVT_W-1:0] == '0 |-> ##2 !irq)
    else $error("interrupt stays after mask cleared");
  k_readback_a: assert property (
    reg_wr && reg_addr == REG_SEC_K ##2 reg_rd && reg_addr == REG_SEC_K
    |=> reg_rdata[ERR_W-1:0] == $past(reg_wdata[ERR_W-1:0], 3))
    else $error("section threshold readback wrong");
endmodule

bind slpm_counters slpm_props u_props (
  .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
  .ring_working_switch_count, .span_switch_count, .ring_switch_count,
  .ring_working_switch_duration, .span_switch_duration, .ring_switch_duration
);

// file: testbench/slpm_line_model.sv
/*
  Behavioural model of the incoming optical line: frame marks with parity
  error counts, defect and failure levels, and the protection selector.
  Assumes its tasks are called just after a rising core_clk edge.
*/
`timescale 1ns/1ps
module slpm_line_model
  import slpm_pkg::*;
(
  input wire logic core_clk,
  output slpm_line_t line
);
  initial line = '0;

  // Replaces the defect, failure and protection levels, keeps frame fields.
  task automatic levels(input slpm_line_t v);
    line <= slpm_line_t'({line[$bits(slpm_line_t)-1:6], v[5:0]});
  endtask

  // Error counts are only valid around the frame mark; outside it they churn.
  task automatic frame(input logic [3:0] b1, input logic [7:0] b2);
    line.frame <= 1'b1;
    line.b1_errs <= b1;
    line.b2_errs <= b2;
    repeat (4) @(posedge core_clk);
    line.frame <= 1'b0;
    repeat (4) begin
      line.b1_errs <= 4'($urandom);
      line.b2_errs <= 8'($urandom);
      @(posedge core_clk);
    end
  endtask
endmodule

// file: testbench/tb.sv
/*
  Self-checking bench for the performance-monitoring counters.
  Assumes the line model drives line_in and the checker is bound.
*/
`timescale 1ns/1ps
module tb;
  import slpm_pkg::*;
  localparam int STS_N  = 3;
  localparam int B2_MAX = 8 * STS_N;
  logic                    core_clk;
  logic                    srst;
  logic                    sec_tick;
  slpm_line_t              line_in;
  slpm_line_t              lv;
  logic [ADDR_W-1:0]       reg_addr;
  logic [CNT_W-1:0]        reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [CNT_W-1:0]        reg_rdata;
  logic                    irq;
  logic                    rd_pend = 1'b0;
  logic [ADDR_W+CNT_W-1:0] exp_q[$];
  int                      x[11];
  int                      sec_k;
  int                      line_k;
  int                      error_cnt = 0;
  int                      compares = 0;

  slpm_counters #(.STS_N(STS_N)) dut (
    .core_clk(core_clk), .srst(srst), .sec_tick(sec_tick), .line_in(line_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .ring_working_switch_count(), .span_switch_count(),
    .ring_switch_count(), .ring_working_switch_duration(), .span_switch_duration(),
    .ring_switch_duration()
  );
  slpm_line_model lm (.core_clk(core_clk), .line(line_in));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [CNT_W-1:0] seen,
                       input logic [CNT_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  always @(posedge core_clk) begin
    if (rd_pend) begin
      check($sformatf("reg %h", exp_q[0][CNT_W+:ADDR_W]), reg_rdata, exp_q[0][CNT_W-1:0]);
      exp_q.delete(0);
    end
    rd_pend <= reg_rd;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] e);
    exp_q.push_back({a, e});
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // Reads every counter, from 0x18 upward, against the running expectation.
  task automatic chk();
    for (int i = 0; i < 11; i++) rd(REG_CV_S + 7'(4 * i), 32'(x[i]));
  endtask

  // One second of line activity; defects drop before the tick unless held.
  task automatic sec(input slpm_line_t v, input int nfr, input bit hold);
    int s1;
    int s2;
    logic [3:0] b1;
    logic [7:0] b2;
    s1 = 0;
    s2 = 0;
    lm.levels(v);
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < nfr; i++) begin
      b1 = 4'($urandom_range(15, 0));
      b2 = 8'($urandom_range(255, 0));
      s1 += (b1 > 8) ? 8 : int'(b1);
      s2 += (b2 > B2_MAX) ? B2_MAX : int'(b2);
      lm.frame(b1, b2);
    end
    if (!hold) lm.levels(slpm_line_t'(v & 19'h1));
    repeat (6) @(posedge core_clk);
    sec_tick <= 1'b1;
    repeat (2) @(posedge core_clk);
    sec_tick <= 1'b0;
    repeat (6) @(posedge core_clk);
    x[0] += s1;
    x[1] += int'(s1 > 0 || v.sef || v.los);
    x[2] += int'(s1 >= sec_k || v.sef || v.los);
    x[3] += int'(v.sef);
    x[4] += s2;
    x[5] += int'(s2 > 0 || v.ais_l);
    x[6] += int'(s2 >= line_k || v.ais_l);
  endtask

  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(83076));
    srst = 1'b1;
    sec_tick = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lv = '0;
    for (int i = 0; i < 11; i++) x[i] = 0;
    sec_k = 1;
    line_k = 1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a <= 'h44; a += 4) begin
      rd(7'(a), (a == 4 || a == 8 || a == 'h14) ? 32'h1 : 32'h0);
    end
    sec_k = $urandom_range(40, 1);
    line_k = $urandom_range(60, 1);
    wr(REG_SEC_K, 32'(sec_k));
    rd(REG_SEC_K, 32'(sec_k));
    wr(REG_LINE_K, 32'(line_k));
    rd(REG_LINE_K, 32'(line_k));
    repeat (4) sec('0, 6, 1'b0);
    chk();
    lv.sef = 1'b1;
    sec(lv, 0, 1'b0);
    lv = '0;
    lv.los = 1'b1;
    lv.ais_l = 1'b1;
    sec(lv, 0, 1'b0);
    chk();
    lv = '0;
    lv.ais_l_fail = 1'b1;
    sec(lv, 0, 1'b0);
    lv = '0;
    lv.lower_fail = 1'b1;
    sec(lv, 0, 1'b1);
    sec(lv, 0, 1'b0);
    sec('0, 0, 1'b0);
    x[8] += 2;
    chk();
    wr(REG_IRQ_STAT, 32'h3f);
    lv = '0;
    lv.ais_l = 1'b1;
    repeat (9) sec(lv, 0, 1'b0);
    sec('0, 0, 1'b0);
    repeat (10) sec(lv, 0, 1'b0);
    repeat (10) sec('0, 0, 1'b0);
    x[7] += 10;
    chk();
    rd(REG_IRQ_STAT, 32'h0d);
    wr(REG_IRQ_MASK, 32'h30);
    @(posedge core_clk);
    check("irq", 32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h08);
    @(posedge core_clk);
    check("irq", 32'(irq), 32'h1);
    wr(REG_IRQ_STAT, 32'h08);
    @(posedge core_clk);
    check("irq", 32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h00);
    lv = '0;
    lv.on_protection = 1'b1;
    sec(lv, 0, 1'b0);
    sec('0, 0, 1'b0);
    chk();
    for (int r = 0; r < 2; r++) begin
      wr(REG_CTRL, 32'(1 + 2 * r));
      sec(lv, 0, 1'b0);
      sec('0, 0, 1'b0);
      // The selector is still seen early in the second after it drops.
      x[9] += 2;
      x[10] += 2;
      chk();
    end
    // The clear command zeroes every counter and drops its own bit.
    wr(REG_CTRL, 32'h4);
    for (int i = 0; i < 11; i++) x[i] = 0;
    chk();
    rd(REG_CTRL, 32'h0);
    wrap_up();
  end
endmodule
